// >>> rtl/asatr_defs.svh
`ifndef ASATR_DEFS_SVH
`define ASATR_DEFS_SVH

// Register locations
`define ASATR_ADDR_TEMP 5'h05
`define ASATR_ADDR_MASK 5'h06
`define ASATR_ADDR_FLAGS 5'h07

// Reset values
`define ASATR_TEMP_RST 8'h00
`define ASATR_MASK_RST 7'h00
`define ASATR_FLAGS_RST 8'h00
`define ASATR_RDATA_RST 8'h00
`define ASATR_UNMAPPED 8'h00

// Alarm flag positions
`define ASATR_BIT_ZERO 6
`define ASATR_BIT_COLL 5
`define ASATR_BIT_PAT 3
`define ASATR_BIT_TWO 1
`define ASATR_BIT_ONE 0

// Implemented flag bits, reserved bits stay zero
`define ASATR_FLAG_IMPL 8'h6B

// Mask field
`define ASATR_MASK_MSB 6
`define ASATR_MASK_ALL 7'h7F

// Write pointer
`define ASATR_WP_RELOAD 8'h01
`define ASATR_WP_EMPTY 8'h00

// Good-sample run before auto-clear: 64 samples
`define ASATR_RUN_RST 6'h00
`define ASATR_RUN_ONE 6'h01
`define ASATR_RUN_LAST 6'h3F

`endif

// >>> rtl/asatr_pkg.sv
package asatr_pkg;

    typedef struct packed {
        logic [4:0] addr;
        logic write;
        logic [7:0] wdata;
    } asatr_req_t;

    typedef struct packed {
        logic zero;
        logic coll;
        logic pat;
        logic two;
        logic one;
    } asatr_evt_t;

endpackage : asatr_pkg

// >>> rtl/asatr_status_regs.sv
`timescale 1ns/1ps
`include "asatr_defs.svh"
// Operation
// RL1: The temperature register shows the sensor's signed Celsius byte unchanged.
// RL2: The host reads the temperature with a serial clock period of at least one microsecond.
// RL3: The temperature register at 0x05 is read-only and ignores writes.
// RL4: A mask bit of one keeps the matching alarm off the shared alert pin.
// RL5: Bit 6 is set whenever the write pointer holds all zeros.
// RL6: An all-zero write pointer stays stuck until the next sync reloads it.
// RL7: The host resynchronises the FIFO after a corrupted-pointer alarm.
// RL8: Bit 5 is set when the FIFO pointers overrun or underrun each other.
// RL9: Bit 3 is set when input data differs from the reference pattern.
// RL10: Bit 1 is set when the pointers are within two addresses.
// RL11: Bit 0 is set when the pointers are within one address.
// RL12: The alarm register at 0x07 resets to zero and a host write clears it.
// RL13: One-apart and two-apart alarms are raised only while their enables are on.
// RL14: With auto-clear on, 64 consecutive good samples clear the flags.
// RL15: Flags latch until cleared and masking never touches them.
// RL16: The alert pin asserts when any unmasked flag is set.
// RL17: Reserved mask and status bits read zero and ignore writes.
module asatr_status_regs (
    input wire logic clk,
    input wire logic resetn,
    input wire logic reqValid,
    input wire asatr_pkg::asatr_req_t req,
    output logic [7:0] rdata,
    input wire logic [7:0] tempSensor,
    input wire logic wrAdvance,
    input wire logic syncEvent,
    input wire logic [7:0] readPointer,
    input wire logic patternMismatch,
    input wire logic goodSample,
    input wire logic one_apart_check_on,
    input wire logic two_apart_check_on,
    input wire logic auto_clear_on_good_run,
    output logic [7:0] writePointer,
    output logic shared_alert_out_pin
);

    logic [7:0] temp_reg, temp_next;
    logic [6:0] mask_reg, mask_next;
    logic [7:0] flags_reg, flags_next;
    logic [7:0] wp_reg, wp_next;
    logic [5:0] run_reg, run_next;
    logic [7:0] rdata_reg, rdata_next;
    logic alert_reg, alert_next;
    logic autoClr;
    logic hostClr;
    logic [7:0] rpNear1, rpNear2;
    asatr_pkg::asatr_evt_t evt;
    logic [7:0] evtBits;

    // Pointer proximity on one-hot shift-register pointers
    assign rpNear1 = readPointer | {readPointer[6:0], readPointer[7]} | {readPointer[0], readPointer[7:1]};
    assign rpNear2 = rpNear1 | {readPointer[5:0], readPointer[7:6]} | {readPointer[1:0], readPointer[7:2]};

    always_comb begin
        evt.zero = (wp_reg == `ASATR_WP_EMPTY); // RL5
        evt.coll = |(wp_reg & readPointer); // RL8
        evt.pat = patternMismatch; // RL9
        evt.two = two_apart_check_on & (|(wp_reg & rpNear2)); // RL10 RL13
        evt.one = one_apart_check_on & (|(wp_reg & rpNear1)); // RL11 RL13
    end

    always_comb begin
        evtBits = `ASATR_FLAGS_RST;
        evtBits[`ASATR_BIT_ZERO] = evt.zero;
        evtBits[`ASATR_BIT_COLL] = evt.coll;
        evtBits[`ASATR_BIT_PAT] = evt.pat;
        evtBits[`ASATR_BIT_TWO] = evt.two;
        evtBits[`ASATR_BIT_ONE] = evt.one;
    end

    // Write pointer
    always_comb begin
        wp_next = wp_reg;
        if (syncEvent) begin
            wp_next = `ASATR_WP_RELOAD;
        end else if (wrAdvance && wp_reg != `ASATR_WP_EMPTY) begin // RL6
            wp_next = {wp_reg[6:0], wp_reg[7]};
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wp_reg <= `ASATR_WP_RELOAD;
        end else begin
            wp_reg <= wp_next;
        end
    end

    // Good-sample run counter
    always_comb begin
        run_next = run_reg;
        autoClr = 1'b0;
        if (|evtBits) begin
            run_next = `ASATR_RUN_RST;
        end else if (goodSample) begin
            if (run_reg == `ASATR_RUN_LAST) begin
                run_next = `ASATR_RUN_RST;
                autoClr = auto_clear_on_good_run; // RL14
            end else begin
                run_next = run_reg + `ASATR_RUN_ONE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            run_reg <= `ASATR_RUN_RST;
        end else begin
            run_reg <= run_next;
        end
    end

    // Registers
    assign hostClr = reqValid && req.write && req.addr == `ASATR_ADDR_FLAGS;

    always_comb begin
        temp_next = tempSensor; // RL1 RL3
        mask_next = mask_reg;
        if (reqValid && req.write && req.addr == `ASATR_ADDR_MASK) begin
            mask_next = req.wdata[`ASATR_MASK_MSB:0]; // RL17
        end
        flags_next = flags_reg;
        if (hostClr || autoClr) begin
            flags_next = `ASATR_FLAGS_RST; // RL12 RL14
        end
        flags_next = (flags_next | evtBits) & `ASATR_FLAG_IMPL; // RL15 RL17
        alert_next = |(flags_next[`ASATR_MASK_MSB:0] & ~mask_next); // RL4 RL16
        rdata_next = rdata_reg;
        if (reqValid && !req.write) begin
            case (req.addr)
                `ASATR_ADDR_TEMP: rdata_next = temp_reg;
                `ASATR_ADDR_MASK: rdata_next = {1'b0, mask_reg}; // RL17
                `ASATR_ADDR_FLAGS: rdata_next = flags_reg;
                default: rdata_next = `ASATR_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            temp_reg <= `ASATR_TEMP_RST;
            mask_reg <= `ASATR_MASK_RST;
            flags_reg <= `ASATR_FLAGS_RST;
            rdata_reg <= `ASATR_RDATA_RST;
            alert_reg <= 1'b0;
        end else begin
            temp_reg <= temp_next;
            mask_reg <= mask_next;
            flags_reg <= flags_next;
            rdata_reg <= rdata_next;
            alert_reg <= alert_next;
        end
    end

    assign rdata = rdata_reg;
    assign writePointer = wp_reg;
    assign shared_alert_out_pin = alert_reg;

    // Checks
    sequence s_read(logic [4:0] a);
        reqValid && !req.write && req.addr == a;
    endsequence

    sequence s_noClear;
        !hostClr && !autoClr;
    endsequence

    property p_temp_follow;
        @(posedge clk) disable iff (!resetn)
        reqValid && req.write && req.addr == `ASATR_ADDR_TEMP |=> temp_reg == $past(tempSensor);
    endproperty
    a_temp_follow: assert property (p_temp_follow) else $error("temperature changed by write"); // RL3

    property p_temp_read;
        @(posedge clk) disable iff (!resetn)
        s_read(`ASATR_ADDR_TEMP) |=> rdata == $past(temp_reg);
    endproperty
    a_temp_read: assert property (p_temp_read) else $error("temperature read mismatch"); // RL1

    property p_mask_rsvd;
        @(posedge clk) disable iff (!resetn)
        s_read(`ASATR_ADDR_MASK) |=> rdata[7] == 1'b0 && rdata[6:0] == $past(mask_reg);
    endproperty
    a_mask_rsvd: assert property (p_mask_rsvd) else $error("mask readback wrong"); // RL17

    property p_alert;
        @(posedge clk) disable iff (!resetn)
        ##1 shared_alert_out_pin == |(flags_reg[`ASATR_MASK_MSB:0] & ~mask_reg);
    endproperty
    a_alert: assert property (p_alert) else $error("alert pin disagrees with flags"); // RL16

    property p_zero_flag;
        @(posedge clk) disable iff (!resetn)
        wp_reg == `ASATR_WP_EMPTY |=> flags_reg[`ASATR_BIT_ZERO];
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero pointer flag missing"); // RL5

    property p_wp_stuck;
        @(posedge clk) disable iff (!resetn)
        wp_reg == `ASATR_WP_EMPTY && !syncEvent |=> wp_reg == `ASATR_WP_EMPTY;
    endproperty
    a_wp_stuck: assert property (p_wp_stuck) else $error("zero pointer moved without sync"); // RL6

    property p_coll;
        @(posedge clk) disable iff (!resetn)
        |(wp_reg & readPointer) |=> flags_reg[`ASATR_BIT_COLL];
    endproperty
    a_coll: assert property (p_coll) else $error("collision flag missing"); // RL8

    property p_pat;
        @(posedge clk) disable iff (!resetn)
        patternMismatch |=> flags_reg[`ASATR_BIT_PAT];
    endproperty
    a_pat: assert property (p_pat) else $error("pattern flag missing"); // RL9

    property p_two;
        @(posedge clk) disable iff (!resetn)
        two_apart_check_on && |(wp_reg & rpNear2) |=> flags_reg[`ASATR_BIT_TWO];
    endproperty
    a_two: assert property (p_two) else $error("two-apart flag missing"); // RL10

    property p_one;
        @(posedge clk) disable iff (!resetn)
        one_apart_check_on && |(wp_reg & rpNear1) |=> flags_reg[`ASATR_BIT_ONE];
    endproperty
    a_one: assert property (p_one) else $error("one-apart flag missing"); // RL11

    property p_one_off;
        @(posedge clk) disable iff (!resetn)
        !one_apart_check_on && !flags_reg[`ASATR_BIT_ONE] |=> !flags_reg[`ASATR_BIT_ONE];
    endproperty
    a_one_off: assert property (p_one_off) else $error("one-apart flag set while disabled"); // RL13

    property p_host_clear;
        @(posedge clk) disable iff (!resetn)
        hostClr && evtBits == `ASATR_FLAGS_RST |=> flags_reg == `ASATR_FLAGS_RST;
    endproperty
    a_host_clear: assert property (p_host_clear) else $error("write did not clear flags"); // RL12

    property p_auto_clear;
        @(posedge clk) disable iff (!resetn)
        goodSample && run_reg == `ASATR_RUN_LAST && auto_clear_on_good_run && evtBits == `ASATR_FLAGS_RST
        |=> flags_reg == `ASATR_FLAGS_RST;
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("auto-clear missed"); // RL14

    property p_latch;
        @(posedge clk) disable iff (!resetn)
        s_noClear ##0 flags_reg[`ASATR_BIT_PAT] |=> flags_reg[`ASATR_BIT_PAT];
    endproperty
    a_latch: assert property (p_latch) else $error("flag dropped without clear"); // RL15

    property p_mask_hides;
        @(posedge clk) disable iff (!resetn)
        mask_reg == `ASATR_MASK_ALL && mask_next == `ASATR_MASK_ALL |=> !shared_alert_out_pin;
    endproperty
    a_mask_hides: assert property (p_mask_hides) else $error("masked alarm reached pin"); // RL4

    property p_two_off;
        @(posedge clk) disable iff (!resetn)
        !two_apart_check_on && !flags_reg[`ASATR_BIT_TWO] |=> !flags_reg[`ASATR_BIT_TWO];
    endproperty
    a_two_off: assert property (p_two_off) else $error("two-apart flag set while disabled"); // RL13

    property p_wp_sync;
        @(posedge clk) disable iff (!resetn)
        syncEvent |=> wp_reg == `ASATR_WP_RELOAD;
    endproperty
    a_wp_sync: assert property (p_wp_sync) else $error("sync did not reload write pointer"); // RL6

    property p_mask_write;
        @(posedge clk) disable iff (!resetn)
        reqValid && req.write && req.addr == `ASATR_ADDR_MASK |=> mask_reg == $past(req.wdata[`ASATR_MASK_MSB:0]);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write not stored"); // RL4

    property p_flags_rsvd;
        @(posedge clk) disable iff (!resetn)
        (flags_reg & ~`ASATR_FLAG_IMPL) == `ASATR_FLAGS_RST;
    endproperty
    a_flags_rsvd: assert property (p_flags_rsvd) else $error("reserved flag bit set"); // RL17

    property p_latch_all;
        @(posedge clk) disable iff (!resetn)
        s_noClear |=> (flags_reg & $past(flags_reg)) == $past(flags_reg);
    endproperty
    a_latch_all: assert property (p_latch_all) else $error("a flag dropped without clear"); // RL15

    property p_auto_off;
        @(posedge clk) disable iff (!resetn)
        !auto_clear_on_good_run && !hostClr && flags_reg[`ASATR_BIT_PAT] |=> flags_reg[`ASATR_BIT_PAT];
    endproperty
    a_auto_off: assert property (p_auto_off) else $error("flags cleared with auto-clear off"); // RL14

    property p_run_reset;
        @(posedge clk) disable iff (!resetn)
        (|evtBits) |=> run_reg == `ASATR_RUN_RST;
    endproperty
    a_run_reset: assert property (p_run_reset) else $error("good run not restarted by alarm"); // RL14

endmodule : asatr_status_regs

// >>> verification/asatr_host_model.sv
`timescale 1ns/1ps
module asatr_host_model #(
    parameter int TEMP_GAP = 40
) (
    input wire logic clk,
    output logic reqValid,
    output asatr_pkg::asatr_req_t req,
    output logic syncEvent
);
    initial begin
        reqValid = 1'b0;
        req = '0;
        syncEvent = 1'b0;
    end

    // One access, request held until the taking edge
    task automatic access(input logic [4:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        reqValid <= 1'b1;
        req <= '{addr: a, write: w, wdata: d};
        @(posedge clk);
        reqValid <= 1'b0;
        req <= '{addr: ~a, write: 1'b0, wdata: ~d};
        if (!w && a == 5'h05) begin
            repeat (TEMP_GAP) @(posedge clk);
        end
    endtask : access

    // Reload the write pointer
    task automatic resync();
        @(posedge clk);
        syncEvent <= 1'b1;
        @(posedge clk);
        syncEvent <= 1'b0;
    endtask : resync
endmodule : asatr_host_model

// >>> verification/alarm_status_and_temp_regs_test.sv
`timescale 1ns/1ps
module alarm_status_and_temp_regs_test;
    logic clk, resetn, reqValid, syncEvent, wrAdvance, patternMismatch, goodSample;
    logic oneOn, twoOn, autoOn, alertPin;
    asatr_pkg::asatr_req_t req;
    logic [7:0] rdata, tempSensor, readPointer, writePointer;
    int mismatches = 0;
    int total_checks = 0;

    asatr_host_model host (.clk(clk), .reqValid(reqValid), .req(req), .syncEvent(syncEvent));
    asatr_status_regs dut (.clk(clk), .resetn(resetn), .reqValid(reqValid), .req(req), .rdata(rdata),
        .tempSensor(tempSensor), .wrAdvance(wrAdvance), .syncEvent(syncEvent), .readPointer(readPointer),
        .patternMismatch(patternMismatch), .goodSample(goodSample), .one_apart_check_on(oneOn),
        .two_apart_check_on(twoOn), .auto_clear_on_good_run(autoOn), .writePointer(writePointer),
        .shared_alert_out_pin(alertPin));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic give_verdict();
        if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic chk1(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1

    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        host.access(a, 1'b0, 8'h00);
        #1;
        chk8($sformatf("reg %h", a), exp, rdata);
    endtask : rd

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host.access(a, 1'b1, d);
        #1;
    endtask : wr

    task automatic pulse_rp(input logic [7:0] rp);
        @(posedge clk) readPointer <= rp;
        @(posedge clk) readPointer <= 8'h10;
        #1;
    endtask : pulse_rp

    task automatic pulse_pat();
        @(posedge clk) patternMismatch <= 1'b1;
        @(posedge clk) patternMismatch <= 1'b0;
        #1;
    endtask : pulse_pat

    task automatic test_reset_and_map();
        rd(5'h06, 8'h00);
        rd(5'h07, 8'h00);
        rd(5'h1F, 8'h00);
        chk1("alert", 1'b0, alertPin);
        chk8("wptr", 8'h01, writePointer);
        wr(5'h06, 8'hFF);
        rd(5'h06, 8'h7F);
        wr(5'h06, 8'h00);
    endtask : test_reset_and_map

    task automatic test_temperature();
        @(posedge clk) tempSensor <= 8'hE7;
        wr(5'h05, 8'h55);
        rd(5'h05, 8'hE7);
    endtask : test_temperature

    task automatic test_pointer_alarms();
        pulse_rp(8'h02);
        rd(5'h07, 8'h00);
        @(posedge clk) begin
            oneOn <= 1'b1;
            twoOn <= 1'b1;
        end
        pulse_rp(8'h04);
        rd(5'h07, 8'h02);
        chk1("alert", 1'b1, alertPin);
        wr(5'h07, 8'h00);
        rd(5'h07, 8'h00);
        pulse_rp(8'h02);
        rd(5'h07, 8'h03);
        wr(5'h07, 8'h00);
        pulse_rp(8'h01);
        rd(5'h07, 8'h23);
        wr(5'h07, 8'h00);
        @(posedge clk) begin
            oneOn <= 1'b0;
            twoOn <= 1'b0;
        end
    endtask : test_pointer_alarms

    task automatic test_mask();
        wr(5'h06, 8'h08);
        pulse_pat();
        rd(5'h07, 8'h08);
        chk1("alert masked", 1'b0, alertPin);
        wr(5'h06, 8'h00);
        chk1("alert unmasked", 1'b1, alertPin);
        @(posedge clk) patternMismatch <= 1'b1;
        wr(5'h07, 8'h00);
        @(posedge clk) patternMismatch <= 1'b0;
        rd(5'h07, 8'h08);
    endtask : test_mask

    task automatic test_auto_clear();
        @(posedge clk) autoOn <= 1'b1;
        repeat (63) begin
            @(posedge clk) goodSample <= 1'b1;
            @(posedge clk) goodSample <= 1'b0;
        end
        rd(5'h07, 8'h08);
        @(posedge clk) goodSample <= 1'b1;
        @(posedge clk) goodSample <= 1'b0;
        rd(5'h07, 8'h00);
        @(posedge clk) autoOn <= 1'b0;
        pulse_pat();
        repeat (64) begin
            @(posedge clk) goodSample <= 1'b1;
            @(posedge clk) goodSample <= 1'b0;
        end
        rd(5'h07, 8'h08);
        wr(5'h07, 8'h00);
    endtask : test_auto_clear

    task automatic test_sync();
        @(posedge clk) wrAdvance <= 1'b1;
        repeat (3) @(posedge clk);
        wrAdvance <= 1'b0;
        #1;
        chk8("wptr advanced", 8'h08, writePointer);
        host.resync();
        #1;
        chk8("wptr resync", 8'h01, writePointer);
        wr(5'h07, 8'h00);
    endtask : test_sync

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        give_verdict();
    end

    initial begin
        resetn = 1'b0;
        {wrAdvance, patternMismatch, goodSample, oneOn, twoOn, autoOn} = '0;
        tempSensor = 8'h00;
        readPointer = 8'h10;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        test_reset_and_map();
        test_temperature();
        test_pointer_alarms();
        test_mask();
        test_auto_clear();
        test_sync();
        give_verdict();
    end
endmodule : alarm_status_and_temp_regs_test
